// [logic/bbpc_pkg.sv]
// package for the backup power control block
// assumes apb with 32-bit data, one 10 MHz clock
package bbpc_pkg;
   // register index; the apb byte address is four times the index
   localparam logic [7:0] CTRL_IDX      = 8'h02;
   localparam logic [7:0] STAT_IDX      = 8'h03;
   localparam logic [7:0] MASK_IDX      = 8'h04;
   localparam logic [7:0] CTRL_OFF      = {CTRL_IDX[5:0], 2'b00};
   localparam logic [7:0] STAT_OFF      = {STAT_IDX[5:0], 2'b00};
   localparam logic [7:0] MASK_OFF      = {MASK_IDX[5:0], 2'b00};
   // sync reset: main below battery and threshold, battery fine
   localparam logic [2:0] SYNC_RESET    = 3'h3;
   localparam logic [7:0] CTRL_RESET    = 8'he0;
   localparam int         PM_HI         = 7;
   localparam int         PM_LO         = 5;
   localparam int         SWF_BIT       = 3;
   localparam int         BLF_BIT       = 2;
   localparam int         SWIE_BIT      = 1;
   localparam int         BATTERY_LOW_IRQ_ENABLE_BIT      = 0;
   localparam logic [2:0] PM_OFF        = 3'h7;
   localparam logic [1:0] EVT_RESET     = 2'h0;
   typedef enum logic [1:0] {
      BBPC_STANDBY = 2'b00,
      BBPC_MAIN    = 2'b01,
      BBPC_BATTERY = 2'b10
   } bbpc_supply_t;
   typedef enum logic [1:0] {
      BBPC_SW_STD  = 2'b00,
      BBPC_SW_DIR  = 2'b01,
      BBPC_SW_OFF  = 2'b10
   } bbpc_swmode_t;
   // switch-over mode from the select field
   function automatic bbpc_swmode_t bbpc_sw_mode(input logic [2:0] pm);
      case (pm)
         3'h0, 3'h4: bbpc_sw_mode = BBPC_SW_STD;
         3'h1, 3'h5: bbpc_sw_mode = BBPC_SW_DIR;
         default:    bbpc_sw_mode = BBPC_SW_OFF;
      endcase
   endfunction
   // battery-low detection on for codes 0..3
   function automatic logic bbpc_bl_on(input logic [2:0] pm);
      bbpc_bl_on = (pm[2] == 1'b0);
   endfunction
endpackage

// [logic/bbpc_cmp_if.sv]
// synchronised comparator levels passed between modules
// assumes one clock domain
`timescale 1ns/1ps
interface bbpc_cmp_if;
   logic main_lt_bat;
   logic main_lt_thr;
   logic bat_low;
   modport src (output main_lt_bat, output main_lt_thr, output bat_low);
   modport dst (input main_lt_bat, input main_lt_thr, input bat_low);
endinterface

// [logic/bbpc_sync.sv]
// two-flop synchronisers for the three comparator inputs
// assumes asynchronous analog comparator levels
`timescale 1ns/1ps
module bbpc_sync
   import bbpc_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   main_lt_bat_raw,
   input  wire logic   main_lt_thr_raw,
   input  wire logic   bat_low_raw,
   bbpc_cmp_if.src     cmp
);
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // main counts as absent until seen, so standby is not left early
         s1_q <= SYNC_RESET;
         s2_q <= SYNC_RESET;
      end else begin
         s1_q <= {bat_low_raw, main_lt_thr_raw, main_lt_bat_raw};
         s2_q <= s1_q;
      end
   end
   assign cmp.main_lt_bat = s2_q[0];
   assign cmp.main_lt_thr = s2_q[1];
   assign cmp.bat_low     = s2_q[2];
endmodule // bbpc_sync

// [logic/bbpc_top.sv]
// backup supply switch-over and battery-low control with apb registers
// assumes comparator levels are asynchronous, apb on CLK
// Behaviour
// - codes 000/100 standard, 001/101 direct
// - 010/011/111 off; low detect for 0xx
// - select field resets to 111
// - standby until main first appears
// - standard: battery if below both
// - direct: battery if main below battery
// - direct mode ignores threshold comparison
// - switch sets flag, interrupt if enabled
// - flag cleared only back on main
// - on battery ignore bus, float outputs
// - switch-over disabled reads flag zero
// - low battery sets flag, also on battery
// - low interrupt follows flag while enabled
// - bus writes never clear low flag
// - active low interrupt shared with clock
// - level interrupt from the masked sticky events
`timescale 1ns/1ps
module bbpc_top
   import bbpc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   input  wire logic        MAIN_LT_BAT,
   input  wire logic        MAIN_LT_THR,
   input  wire logic        BAT_LOW,
   input  wire logic        CLOCK_OUTPUT_EN,
   input  wire logic        CLOCK_OUTPUT_IN,
   output logic             PRIMARY_IRQ_OUT_N,
   output logic             PRIMARY_IRQ_OE,
   output logic             ON_BATTERY,
   output logic             IF_OUT_EN,
   output logic             IRQ
);
   bbpc_cmp_if cmp ();
   logic [2:0]   pm_q;
   logic         swf_q;
   logic         blf_q;
   logic         swie_q;
   logic         battery_low_irq_enable_q;
   logic [1:0]   evt_q;
   logic [1:0]   mask_q;
   bbpc_supply_t sup_q;
   bbpc_supply_t sup_d;
   bbpc_swmode_t mode;
   logic         fail;
   logic         acc;
   logic         wr;
   logic         rd;
   logic         swf_rd;
   logic         irq_d;
   logic         ck_s1_q;
   logic         ck_s2_q;

   bbpc_sync u_sync (
      .clk             (CLK),
      .rst             (SYS_RST),
      .main_lt_bat_raw (MAIN_LT_BAT),
      .main_lt_thr_raw (MAIN_LT_THR),
      .bat_low_raw     (BAT_LOW),
      .cmp             (cmp)
   );

   assign mode = bbpc_sw_mode(pm_q);

   always_comb begin
      case (mode)
         BBPC_SW_STD: fail = cmp.main_lt_bat & cmp.main_lt_thr;
         BBPC_SW_DIR: fail = cmp.main_lt_bat;
         default:     fail = 1'b0;
      endcase
   end

   always_comb begin
      sup_d = sup_q;
      case (sup_q)
         BBPC_STANDBY: if (!cmp.main_lt_bat) sup_d = BBPC_MAIN;
         BBPC_MAIN:    if (fail) sup_d = BBPC_BATTERY;
         BBPC_BATTERY: if (!fail) sup_d = BBPC_MAIN;
         default:      sup_d = BBPC_STANDBY;
      endcase
      if (sup_q == BBPC_MAIN && mode == BBPC_SW_OFF && cmp.main_lt_bat
          && cmp.main_lt_thr)
         sup_d = BBPC_STANDBY;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) sup_q <= BBPC_STANDBY;
      else sup_q <= sup_d;
   end

   assign acc = PSEL & PENABLE & (sup_q == BBPC_MAIN);
   assign wr  = acc & PWRITE;
   assign rd  = acc & ~PWRITE;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pm_q   <= CTRL_RESET[PM_HI:PM_LO];
         swie_q <= 1'b0;
         battery_low_irq_enable_q <= 1'b0;
      end else if (wr && PADDR == CTRL_OFF) begin
         if (PWDATA[PM_HI:PM_LO] != 3'h6) pm_q <= PWDATA[PM_HI:PM_LO];
         swie_q <= PWDATA[SWIE_BIT];
         battery_low_irq_enable_q <= PWDATA[BATTERY_LOW_IRQ_ENABLE_BIT];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) swf_q <= 1'b0;
      else if (sup_q == BBPC_MAIN && sup_d == BBPC_BATTERY) swf_q <= 1'b1;
      else if (wr && PADDR == CTRL_OFF && !PWDATA[SWF_BIT]) swf_q <= 1'b0;
   end

   assign swf_rd = swf_q & (mode != BBPC_SW_OFF);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) blf_q <= 1'b0;
      else if (bbpc_bl_on(pm_q)) blf_q <= cmp.bat_low;
      else if (!cmp.bat_low) blf_q <= 1'b0;
   end

   // clock output state is a pin, so it is synchronised
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ck_s1_q <= 1'b1;
         ck_s2_q <= 1'b1;
      end else begin
         ck_s1_q <= CLOCK_OUTPUT_IN;
         ck_s2_q <= ck_s1_q;
      end
   end

   assign irq_d = (swf_rd & swie_q) | (blf_q & battery_low_irq_enable_q);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PRIMARY_IRQ_OUT_N <= 1'b1;
         PRIMARY_IRQ_OE    <= 1'b0;
      end else if (CLOCK_OUTPUT_EN) begin
         PRIMARY_IRQ_OUT_N <= ck_s2_q;
         PRIMARY_IRQ_OE    <= ~ck_s2_q;
      end else begin
         PRIMARY_IRQ_OUT_N <= ~irq_d;
         PRIMARY_IRQ_OE    <= irq_d;
      end
   end

   // sticky events; a set in the read cycle wins over the clear
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) evt_q <= EVT_RESET;
      else begin
         if (rd && PADDR == STAT_OFF) evt_q <= EVT_RESET;
         if (sup_q == BBPC_MAIN && sup_d == BBPC_BATTERY) evt_q[0] <= 1'b1;
         if (bbpc_bl_on(pm_q) && cmp.bat_low && !blf_q) evt_q[1] <= 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) mask_q <= 2'h0;
      else if (wr && PADDR == MASK_OFF) mask_q <= PWDATA[1:0];
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) IRQ <= 1'b0;
      else IRQ <= |(evt_q & mask_q);
   end

   // apb answers in the access cycle; pready and rdata registered
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE & ~PREADY;
         PSLVERR <= 1'b0;
         if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
               CTRL_OFF: PRDATA <= {24'h0, pm_q, 1'b0, swf_rd, blf_q,
                                    swie_q, battery_low_irq_enable_q};
               STAT_OFF: PRDATA <= {30'h0, evt_q};
               MASK_OFF: PRDATA <= {30'h0, mask_q};
               default:  PRDATA <= 32'h0;
            endcase
         end
         if (PSEL && !PENABLE && PADDR != CTRL_OFF && PADDR != STAT_OFF
             && PADDR != MASK_OFF)
            PSLVERR <= 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ON_BATTERY <= 1'b0;
         IF_OUT_EN  <= 1'b0;
      end else begin
         ON_BATTERY <= (sup_d == BBPC_BATTERY);
         IF_OUT_EN  <= (sup_d == BBPC_MAIN);
      end
   end

   reset_pm_a: assert property (@(posedge CLK)
      $fell(SYS_RST) |-> pm_q == PM_OFF)
      else $error("select field not 111 after reset");
   flag_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (mode == BBPC_SW_OFF && PSEL && PENABLE && !PWRITE
       && PADDR == CTRL_OFF) |-> !PRDATA[SWF_BIT])
      else $error("switch flag visible while disabled");
   flag_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sup_q == BBPC_MAIN && sup_d == BBPC_BATTERY) |=> swf_q)
      else $error("switch flag not set");
   bat_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      sup_q != BBPC_MAIN |=> $stable(pm_q) && $stable(battery_low_irq_enable_q))
      else $error("write taken on battery");
   direct_sw_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sup_q == BBPC_MAIN && mode == BBPC_SW_DIR && cmp.main_lt_bat)
      |=> sup_q == BBPC_BATTERY)
      else $error("direct mode did not switch");
   std_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sup_q == BBPC_MAIN && mode == BBPC_SW_STD && !cmp.main_lt_thr)
      |=> sup_q != BBPC_BATTERY)
      else $error("standard mode switched above threshold");
   low_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      blf_q && cmp.bat_low |=> blf_q)
      else $error("low flag cleared while battery low");
   irq_pin_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !CLOCK_OUTPUT_EN |=> PRIMARY_IRQ_OUT_N == !$past(irq_d))
      else $error("irq pin wrong");
   no_six_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      pm_q != 3'h6)
      else $error("select field holds 110");
   low_irq_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (!CLOCK_OUTPUT_EN && blf_q && battery_low_irq_enable_q) |=> !PRIMARY_IRQ_OUT_N)
      else $error("low battery interrupt not on pin");
   low_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (!blf_q && !bbpc_bl_on(pm_q)) |=> !blf_q)
      else $error("low flag set with detection off");
   low_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (bbpc_bl_on(pm_q) && cmp.bat_low) |=> blf_q)
      else $error("low flag not set");
   standby_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sup_q == BBPC_STANDBY && cmp.main_lt_bat) |=> sup_q == BBPC_STANDBY)
      else $error("left standby without main supply");
   sw_keep_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      (swf_q && sup_q != BBPC_MAIN) |=> swf_q)
      else $error("switch flag cleared away from main");
   if_float_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      sup_q != BBPC_MAIN |-> !IF_OUT_EN)
      else $error("interface enabled off main");
   // covers for the main scenarios
   sw_c: cover property (@(posedge CLK) sup_q == BBPC_BATTERY);
   low_c: cover property (@(posedge CLK) blf_q && battery_low_irq_enable_q);
   back_c: cover property (@(posedge CLK)
      sup_q == BBPC_BATTERY ##1 sup_q == BBPC_MAIN);
   stby_c: cover property (@(posedge CLK)
      sup_q == BBPC_MAIN ##1 sup_q == BBPC_STANDBY);
   ckout_c: cover property (@(posedge CLK) CLOCK_OUTPUT_EN && !ck_s2_q);
endmodule // bbpc_top

// [tb/bbpc_cmp_model.sv]
// supply and battery comparator front end, levels in millivolts
// assumes the bench moves supply levels just after a clock edge
`timescale 1ns/1ps
module bbpc_cmp_model #(
   parameter int THR_MV = 2500,
   parameter int LOW_MV = 2500
) (
   input  wire logic [15:0] main_mv,
   input  wire logic [15:0] bat_mv,
   output logic             main_lt_bat,
   output logic             main_lt_thr,
   output logic             bat_low
);
   assign main_lt_bat = main_mv < bat_mv;
   assign main_lt_thr = main_mv < THR_MV;
   assign bat_low = bat_mv < LOW_MV;
endmodule // bbpc_cmp_model

// [tb/battery_backup_power_control_test.sv]
// bench for the backup power control block over apb
// assumes zero wait-state apb and a few cycles of comparator latency
`timescale 1ns/1ps
module battery_backup_power_control_test;
   import bbpc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, irq_n, irq_oe, on_bat;
   logic        if_en, irq, lt_bat, lt_thr, low;
   logic        ck_en = 1'b0, ck_in = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic [15:0] main_mv = 16'd3300, bat_mv = 16'd3000;
   logic        ev;
   int          mismatches = 0, samples_checked = 0, cycles = 0;
   always #50 clk = ~clk;
   bbpc_cmp_model model_u (.main_mv(main_mv), .bat_mv(bat_mv),
      .main_lt_bat(lt_bat), .main_lt_thr(lt_thr), .bat_low(low));
   bbpc_top dut_u (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .MAIN_LT_BAT(lt_bat), .MAIN_LT_THR(lt_thr), .BAT_LOW(low),
      .CLOCK_OUTPUT_EN(ck_en), .CLOCK_OUTPUT_IN(ck_in),
      .PRIMARY_IRQ_OUT_N(irq_n), .PRIMARY_IRQ_OE(irq_oe),
      .ON_BATTERY(on_bat), .IF_OUT_EN(if_en), .IRQ(irq));
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // bench limit, the tests take a few hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk("read data", rv, x);
   endtask
   // comparators need sync plus state and output edges
   task automatic supply(input logic [15:0] m, input logic [15:0] b);
      main_mv <= m;
      bat_mv  <= b;
      repeat (8) @(posedge clk);
   endtask
   task automatic pins(input logic n, input logic ob, input logic q);
      chk("irq pin", {31'h0, irq_n}, {31'h0, n});
      chk("irq enable", {31'h0, irq_oe}, {31'h0, ~n});
      chk("on battery", {31'h0, on_bat}, {31'h0, ob});
      chk("irq", {31'h0, irq}, {31'h0, q});
   endtask
   logic [2:0] c;
   logic [2:0] sw_codes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
   logic [2:0] off_codes [2] = '{3'h3, 3'h7};
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      supply(16'd3300, 16'd3000);
      chk("if enable", {31'h0, if_en}, 32'h1);
      rd(CTRL_OFF, 32'he0);
      pins(1'b1, 1'b0, 1'b0);
      $display("test reset done");
      xfer(1'b1, MASK_OFF, 32'h1);
      foreach (sw_codes[i]) begin
         c = sw_codes[i];
         xfer(1'b1, CTRL_OFF, {24'h0, c, 5'h02});
         supply(16'd2800, 16'd3000);
         chk("direct", {31'h0, on_bat}, {31'h0, c[0]});
         supply(16'd2000, 16'd3000);
         pins(1'b0, 1'b1, 1'b1);
         chk("if enable", {31'h0, if_en}, 32'h0);
         xfer(1'b1, CTRL_OFF, 32'h0);
         supply(16'd3300, 16'd3000);
         pins(1'b0, 1'b0, 1'b1);
         rd(CTRL_OFF, {24'h0, c, 5'h0a});
         rd(STAT_OFF, 32'h1);
         rd(STAT_OFF, 32'h0);
         xfer(1'b1, CTRL_OFF, {24'h0, c, 5'h02});
         repeat (3) @(posedge clk);
         pins(1'b1, 1'b0, 1'b0);
      end
      $display("test switch modes done");
      supply(16'd2000, 16'd3000);
      supply(16'd3300, 16'd3000);
      rd(STAT_OFF, 32'h1);
      xfer(1'b1, CTRL_OFF, 32'h48);
      rd(CTRL_OFF, 32'h40);
      foreach (off_codes[i]) begin
         c = off_codes[i];
         xfer(1'b1, CTRL_OFF, {24'h0, c, 5'h08});
         rd(CTRL_OFF, {24'h0, c, 5'h00});
      end
      // code 110 must leave the select field alone
      xfer(1'b1, CTRL_OFF, 32'hc2);
      rd(CTRL_OFF, 32'he2);
      $display("test disabled codes done");
      xfer(1'b1, CTRL_OFF, 32'h01);
      supply(16'd3300, 16'd2000);
      rd(CTRL_OFF, 32'h05);
      pins(1'b0, 1'b0, 1'b0);
      xfer(1'b1, CTRL_OFF, 32'h01);
      rd(CTRL_OFF, 32'h05);
      rd(STAT_OFF, 32'h2);
      xfer(1'b1, CTRL_OFF, 32'h00);
      repeat (3) @(posedge clk);
      pins(1'b1, 1'b0, 1'b0);
      supply(16'd3300, 16'd3000);
      rd(CTRL_OFF, 32'h00);
      xfer(1'b1, CTRL_OFF, 32'h81);
      supply(16'd3300, 16'd2000);
      rd(CTRL_OFF, 32'h81);
      supply(16'd3300, 16'd3000);
      $display("test battery low done");
      xfer(1'b0, 8'h20, 32'h0);
      chk("unmapped data", rv, 32'h0);
      chk("unmapped error", {31'h0, ev}, 32'h1);
      // standby: software selects 111, then main goes away
      xfer(1'b1, CTRL_OFF, 32'he0);
      supply(16'd2000, 16'd3000);
      chk("standby", {30'h0, on_bat, if_en}, 32'h0);
      supply(16'd3300, 16'd3000);
      chk("if enable", {31'h0, if_en}, 32'h1);
      $display("test standby done");
      // clock output owns the shared pin while enabled
      ck_en <= 1'b1;
      ck_in <= 1'b0;
      repeat (4) @(posedge clk);
      pins(1'b0, 1'b0, 1'b0);
      ck_in <= 1'b1;
      repeat (4) @(posedge clk);
      pins(1'b1, 1'b0, 1'b0);
      ck_en <= 1'b0;
      $display("test shared pin done");
      close_out;
   end
endmodule // battery_backup_power_control_test
